// *** hw/sbe_pkg.sv ***
// Shared constants and types for the SMBus block buffer and slave event logic
package sbe_pkg;
    // Register offsets on the byte-wide I/O port
    localparam logic [3:0] OFF_HOST_CTL = 4'h2;
    localparam logic [3:0] OFF_BLK_DATA = 4'h7;
    localparam logic [3:0] OFF_SLV_CTL = 4'h8;
    localparam logic [3:0] OFF_CAP_CMD = 4'h9;
    localparam logic [3:0] OFF_MASK_LO = 4'hA;
    localparam logic [3:0] OFF_MASK_HI = 4'hB;
    localparam logic [3:0] OFF_DATA_LO = 4'hC;
    localparam logic [3:0] OFF_DATA_HI = 4'hD;
    // Slave control bit positions
    localparam int BIT_SLAVE_PORT_ENABLE = 0;
    localparam int BIT_FIRST_SHADOW_ENABLE = 1;
    localparam int BIT_SECOND_SHADOW_ENABLE = 2;
    localparam int BIT_ALERT_EN = 3;
    localparam int SLV_CTL_W = 4;
    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [SLV_CTL_W-1:0] RST_CTL = 4'h0;
    // Host slave port address byte, bit 0 is the direction bit
    localparam logic [7:0] HOST_SLV_ADDR = 8'h10;
    // Block array and buffering
    localparam int BLK_DEPTH = 32;
    localparam int BLK_IDX_W = 5;
    localparam int FIFO_DEPTH = 16;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] MAX_DATA_BYTES = 2'h2;
    // Slave receive states, Gray coded along the write path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_CMD = 3'h2,
        ST_CMD_ACK = 3'h6,
        ST_DATA = 3'h7,
        ST_DATA_ACK = 3'h5,
        ST_WAIT = 3'h4
    } sbe_state_e;
endpackage

// *** hw/sbe_fifo.sv ***
// Synchronous valid/ready FIFO with parameter width and depth
`timescale 1ns/1ps
module sbe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic ready_q;
    wire push = in_valid & ready_q;
    wire pop = out_valid & out_ready;

    // Occupancy; ready is registered so the source sees a clean flag
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_ptr_q];

    // Pointer and count update
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_q + AW'(push);
            rd_ptr_q <= rd_ptr_q + AW'(pop);
            cnt_q <= cnt_d;
            ready_q <= (cnt_d < (AW+1)'(DEPTH));
        end
    end

    // Storage, not reset
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end
endmodule

// *** hw/sbe_slave_events.sv ***
// Block data buffer, SMBus slave port capture and event generation
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module sbe_slave_events
    import sbe_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Byte-wide register port
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Slave match settings held by neighbouring registers
    input wire logic [7:0] shadow1_addr,
    input wire logic [7:0] shadow2_addr,
    input wire logic [7:0] slave_cmd_match,
    // Host engine block stream
    input wire logic eng_start,
    input wire logic eng_rx_valid,
    input wire logic [7:0] eng_rx_data,
    output logic eng_rx_ready,
    input wire logic eng_tx_req,
    output logic eng_tx_valid,
    output logic [7:0] eng_tx_data,
    // SMBus pins
    input wire logic smb_clk_in,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe,
    input wire logic smb_alert_n_in,
    // Interrupt or resume event
    output logic slave_event
);
    ////////////////////////////////////////////////////////////////////////////
    // Register file and block array
    logic [7:0] blk_mem_q [BLK_DEPTH];
    logic [BLK_IDX_W-1:0] sw_idx_q;
    logic [BLK_IDX_W-1:0] eng_idx_q;
    logic [SLV_CTL_W-1:0] ctl_q;
    logic [15:0] mask_q;
    logic [7:0] cap_cmd_q;
    logic [15:0] cap_data_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;
    logic tx_valid_q;
    logic [7:0] tx_data_q;
    logic fifo_valid;
    logic [7:0] fifo_data;

    // Access decode
    wire host_ctl_rd = io_rd & (io_addr == OFF_HOST_CTL);
    wire blk_sel = (io_addr == OFF_BLK_DATA);
    wire blk_wr = io_wr & blk_sel;
    wire blk_acc = (io_wr | io_rd) & blk_sel;
    // A software array write owns the write port; the FIFO waits
    wire fifo_ready = ~blk_wr;
    wire fifo_pop = fifo_valid & fifo_ready;

    // Read data selection; reserved control bits and unmapped offsets read zero
    assign rd_mux = blk_sel ? blk_mem_q[sw_idx_q] :
                    (io_addr == OFF_SLV_CTL) ? {{(8-SLV_CTL_W){1'b0}}, ctl_q} :
                    (io_addr == OFF_CAP_CMD) ? cap_cmd_q :
                    (io_addr == OFF_MASK_LO) ? mask_q[7:0] :
                    (io_addr == OFF_MASK_HI) ? mask_q[15:8] :
                    (io_addr == OFF_DATA_LO) ? cap_data_q[7:0] :
                    (io_addr == OFF_DATA_HI) ? cap_data_q[15:8] : RST_BYTE;

    // Incoming block bytes are buffered so a busy array stalls the engine
    sbe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(eng_rx_valid),
        .in_data(eng_rx_data),
        .in_ready(eng_rx_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_ready)
    );

    // Array write port: software first, engine stream otherwise
    always_ff @(posedge clk_sys) begin
        if (blk_wr) begin
            blk_mem_q[sw_idx_q] <= io_wdata;
        end else if (fifo_pop) begin
            blk_mem_q[eng_idx_q] <= fifo_data;
        end
    end

    // Software index pointer
    always_ff @(posedge clk_sys) begin
        if (sys_rst || host_ctl_rd) begin
            sw_idx_q <= '0;
        end else if (blk_acc) begin
            sw_idx_q <= sw_idx_q + BLK_IDX_W'(1);
        end
    end

    // Engine index pointer, restarted per transaction
    always_ff @(posedge clk_sys) begin
        if (sys_rst || eng_start) begin
            eng_idx_q <= '0;
        end else if (fifo_pop || eng_tx_req) begin
            eng_idx_q <= eng_idx_q + BLK_IDX_W'(1);
        end
    end

    // Outgoing block bytes, one per request
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_valid_q <= 1'b0;
            tx_data_q <= RST_BYTE;
        end else begin
            tx_valid_q <= eng_tx_req;
            tx_data_q <= eng_tx_req ? blk_mem_q[eng_idx_q] : tx_data_q;
        end
    end

    // Writable registers and read data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctl_q <= RST_CTL;
            mask_q <= RST_WORD;
            rdata_q <= RST_BYTE;
        end else begin
            if (io_wr && io_addr == OFF_SLV_CTL) ctl_q <= io_wdata[SLV_CTL_W-1:0];
            if (io_wr && io_addr == OFF_MASK_LO) mask_q[7:0] <= io_wdata;
            if (io_wr && io_addr == OFF_MASK_HI) mask_q[15:8] <= io_wdata;
            if (io_rd) rdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, alr_m, alr_s, alr_p;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {scl_m, scl_s, scl_p} <= 3'h7;
            {sda_m, sda_s, sda_p} <= 3'h7;
            {alr_m, alr_s, alr_p} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_p} <= {smb_clk_in, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {smb_data_in, sda_m, sda_s};
            {alr_m, alr_s, alr_p} <= {smb_alert_n_in, alr_m, alr_s};
        end
    end

    // Bus conditions
    wire start_c = scl_s & sda_p & ~sda_s;
    wire stop_c = scl_s & ~sda_p & sda_s;
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire alert_fall = alr_p & ~alr_s;

    ////////////////////////////////////////////////////////////////////////////
    // Slave receiver
    sbe_state_e st_q;
    logic [3:0] bcnt_q;
    logic [7:0] shift_q;
    logic oe_q;
    logic hit_host_q, hit_sh1_q, hit_sh2_q, got_cmd_q;
    logic [1:0] dcnt_q;
    logic [7:0] cmd_stage_q, dlo_q, dhi_q;
    logic event_q;

    // Address compare ignores the direction bit; only writes are claimed
    wire is_wr = ~shift_q[0];
    wire m_host = is_wr & (shift_q[7:1] == HOST_SLV_ADDR[7:1]);
    wire m_sh1 = is_wr & ctl_q[BIT_FIRST_SHADOW_ENABLE] & (shift_q[7:1] == shadow1_addr[7:1]);
    wire m_sh2 = is_wr & ctl_q[BIT_SECOND_SHADOW_ENABLE] & (shift_q[7:1] == shadow2_addr[7:1]);
    wire byte_done = (bcnt_q == BYTE_BITS);
    wire any_hit = hit_host_q | hit_sh1_q | hit_sh2_q;
    wire [15:0] new_data = {dhi_q, dlo_q};
    wire host_evt = hit_host_q & got_cmd_q & ctl_q[BIT_SLAVE_PORT_ENABLE]
                    & (cmd_stage_q == slave_cmd_match) & |(mask_q & new_data);
    wire stop_evt = stop_c & (host_evt | hit_sh1_q | hit_sh2_q);
    wire alert_evt = alert_fall & ctl_q[BIT_ALERT_EN];

    // Bit shifter
    always_ff @(posedge clk_sys) begin
        if (sys_rst || start_c) begin
            shift_q <= RST_BYTE;
        end else if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
        end
    end

    // Transfer sequencer; acknowledge is driven from one clock fall to the next
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            bcnt_q <= 4'h0;
            oe_q <= 1'b0;
            {hit_host_q, hit_sh1_q, hit_sh2_q, got_cmd_q} <= 4'h0;
            dcnt_q <= 2'h0;
        end else if (start_c) begin
            st_q <= ST_ADDR;
            bcnt_q <= 4'h0;
            oe_q <= 1'b0;
            {hit_host_q, hit_sh1_q, hit_sh2_q, got_cmd_q} <= 4'h0;
            dcnt_q <= 2'h0;
        end else if (stop_c) begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
        end else if (scl_rise && !byte_done) begin
            bcnt_q <= bcnt_q + 4'h1;
        end else if (scl_fall) begin
            case (st_q)
                ST_ADDR: begin
                    if (byte_done) begin
                        oe_q <= m_host | m_sh1 | m_sh2;
                        {hit_host_q, hit_sh1_q, hit_sh2_q} <= {m_host, m_sh1, m_sh2};
                        st_q <= (m_host | m_sh1 | m_sh2) ? ST_ADDR_ACK : ST_WAIT;
                    end
                end
                ST_CMD: begin
                    if (byte_done) begin
                        oe_q <= 1'b1;
                        got_cmd_q <= 1'b1;
                        st_q <= ST_CMD_ACK;
                    end
                end
                ST_DATA: begin
                    if (byte_done) begin
                        oe_q <= (dcnt_q < MAX_DATA_BYTES);
                        dcnt_q <= dcnt_q + 2'h1;
                        st_q <= (dcnt_q < MAX_DATA_BYTES) ? ST_DATA_ACK : ST_WAIT;
                    end
                end
                ST_ADDR_ACK: begin
                    oe_q <= 1'b0;
                    bcnt_q <= 4'h0;
                    st_q <= ST_CMD;
                end
                ST_CMD_ACK, ST_DATA_ACK: begin
                    oe_q <= 1'b0;
                    bcnt_q <= 4'h0;
                    st_q <= ST_DATA;
                end
                default: begin
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Staging of command and data bytes until the stop condition
    always_ff @(posedge clk_sys) begin
        if (sys_rst || start_c) begin
            {cmd_stage_q, dlo_q, dhi_q} <= {RST_BYTE, RST_WORD};
        end else if (scl_fall && byte_done) begin
            if (st_q == ST_CMD) cmd_stage_q <= shift_q;
            if (st_q == ST_DATA && dcnt_q == 2'h0) dlo_q <= shift_q;
            if (st_q == ST_DATA && dcnt_q == 2'h1) dhi_q <= shift_q;
        end
    end

    // Commit captures and raise events; only claimed accesses update
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cap_cmd_q <= RST_BYTE;
            cap_data_q <= RST_WORD;
            event_q <= 1'b0;
        end else begin
            if (stop_c && any_hit && got_cmd_q) begin
                cap_cmd_q <= cmd_stage_q;
                cap_data_q <= new_data;
            end
            event_q <= alert_evt | stop_evt;
        end
    end

    // Outputs; the pin is only ever pulled low
    assign io_rdata = rdata_q;
    assign eng_tx_valid = tx_valid_q;
    assign eng_tx_data = tx_data_q;
    assign smb_data_out = 1'b0;
    assign smb_data_oe = oe_q;
    assign slave_event = event_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_hit_stop;
        stop_c && any_hit && got_cmd_q;
    endsequence
    sequence s_blk_write;
        blk_wr ##1 1'b1;
    endsequence

    chk_blk_store: assert property (s_blk_write |->
        blk_mem_q[BLK_IDX_W'(sw_idx_q - BLK_IDX_W'(1))] == $past(io_wdata))
        else $error("block write not stored");
    chk_idx_clear: assert property (host_ctl_rd |=> sw_idx_q == '0)
        else $error("index not cleared");
    chk_idx_step: assert property (blk_acc |=>
        sw_idx_q == BLK_IDX_W'($past(sw_idx_q) + BLK_IDX_W'(1)))
        else $error("index did not advance");
    chk_eng_restart: assert property (eng_start |=> eng_idx_q == '0)
        else $error("engine index not zero");
    chk_alert_event: assert property (alert_fall |=>
        slave_event == $past(ctl_q[BIT_ALERT_EN]) || $past(stop_evt))
        else $error("alert event wrong");
    chk_shadow2_evt: assert property (stop_c && hit_sh2_q |=> slave_event)
        else $error("second shadow event missing");
    chk_shadow1_evt: assert property (stop_c && hit_sh1_q |=> slave_event)
        else $error("first shadow event missing");
    chk_host_evt: assert property (stop_c && hit_host_q && !hit_sh1_q && !hit_sh2_q
        && !alert_evt |=> slave_event == $past(host_evt))
        else $error("host event wrong");
    chk_mask_gate: assert property (stop_c && ~|(mask_q & new_data) && !hit_sh1_q
        && !hit_sh2_q && !alert_evt |=> !slave_event)
        else $error("event without mask hit");
    chk_cmd_capture: assert property (s_hit_stop |=> cap_cmd_q == $past(cmd_stage_q))
        else $error("command not captured");
    chk_data_capture: assert property (s_hit_stop |=> cap_data_q == $past(new_data))
        else $error("data not captured");
    chk_ack_claim: assert property ($rose(oe_q) && st_q == ST_ADDR_ACK |-> any_hit)
        else $error("unclaimed address acknowledged");
endmodule

// *** verif/sbe_smb_master.sv ***
// Behavioural external SMBus master and alert source for the slave port
`timescale 1ns/1ps
module sbe_smb_master #(
    parameter int HALF_NS = 24
) (
    // Resolved data wire
    input wire logic sda_wire,
    // Driven pins, data released high through the pull-up
    output logic scl,
    output logic sda_drv,
    output logic alert_n
);
    // Idle bus: clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        alert_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Start condition: data falls while the clock is high
    task automatic send_start();
        sda_drv = 1'b1;
        scl = 1'b1;
        #HALF_NS sda_drv = 1'b0;
        #HALF_NS scl = 1'b0;
    endtask
    // One byte, MSB first, then the acknowledge slot; data moves only with the clock low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #4 sda_drv = b[i];
            #HALF_NS scl = 1'b1;
            #HALF_NS scl = 1'b0;
        end
        #4 sda_drv = 1'b1;
        #HALF_NS scl = 1'b1;
        #(HALF_NS / 2) ack = ~sda_wire;
        #(HALF_NS / 2) scl = 1'b0;
    endtask
    // Stop condition: data rises while the clock is high
    task automatic send_stop();
        #4 sda_drv = 1'b0;
        #HALF_NS scl = 1'b1;
        #HALF_NS sda_drv = 1'b1;
        #HALF_NS;
    endtask
    // Alert line pulled low long enough to pass the synchroniser
    task automatic alert_pulse();
        alert_n = 1'b0;
        #80 alert_n = 1'b1;
        #80;
    endtask
endmodule

// *** verif/sbe_slave_events_tb.sv ***
// Self-checking bench for the block buffer and slave event logic
`timescale 1ns/1ps
module sbe_slave_events_tb;
    import sbe_pkg::*;
    logic clk_sys;
    logic sys_rst;
    logic [3:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic [7:0] sh1;
    logic [7:0] sh2;
    logic [7:0] slave_cmd_match;
    logic eng_start;
    logic eng_rx_valid;
    logic [7:0] eng_rx_data;
    logic eng_rx_ready;
    logic eng_tx_req;
    logic eng_tx_valid;
    logic [7:0] eng_tx_data;
    logic scl;
    logic sda_drv;
    logic alert_n;
    logic smb_data_out;
    logic smb_data_oe;
    logic slave_event;
    wire sda_level;
    int miscompares = 0;
    int checks = 0;
    int ev_cnt = 0;
    int cyc = 0;
    integer seed = 32'hdaac8ef3;
    logic [7:0] blk [32];
    // Open-drain data wire: low when either party pulls it
    assign sda_level = (smb_data_oe ? smb_data_out : 1'b1) & sda_drv;
    sbe_slave_events u_sbe_slave_events (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .shadow1_addr(sh1),
        .shadow2_addr(sh2), .slave_cmd_match(slave_cmd_match), .eng_start(eng_start),
        .eng_rx_valid(eng_rx_valid), .eng_rx_data(eng_rx_data), .eng_rx_ready(eng_rx_ready),
        .eng_tx_req(eng_tx_req), .eng_tx_valid(eng_tx_valid), .eng_tx_data(eng_tx_data),
        .smb_clk_in(scl), .smb_data_in(sda_level), .smb_data_out(smb_data_out),
        .smb_data_oe(smb_data_oe), .smb_alert_n_in(alert_n), .slave_event(slave_event));
    sbe_smb_master u_sbe_smb_master (.sda_wire(sda_level), .scl(scl), .sda_drv(sda_drv),
        .alert_n(alert_n));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, event counter and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (slave_event === 1'b1) ev_cnt++;
        if (cyc == 30000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Register port cycles, one strobe cycle each, driven at the falling edge
    task automatic io_wr_t(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk_sys);
        io_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk_sys);
        io_rd = 1'b0;
        check({8'h00, io_rdata}, {8'h00, e});
    endtask
    task automatic pulse_start();
        @(negedge clk_sys);
        eng_start = 1'b1;
        @(negedge clk_sys);
        eng_start = 1'b0;
    endtask
    // Expected {claimed, event} for one slave write transaction
    function automatic logic [1:0] exp_out(input logic [3:0] c, input logic [7:0] a,
        input logic [7:0] cm, input logic [15:0] d, input logic [15:0] m);
        logic host;
        logic s1;
        logic s2;
        host = (a == 8'h10);
        s1 = c[1] && (a[7:1] == sh1[7:1]) && !a[0];
        s2 = c[2] && (a[7:1] == sh2[7:1]) && !a[0];
        return {host || s1 || s2,
            (c[0] && host && cm == slave_cmd_match && (m & d) != 16'h0) || s1 || s2};
    endfunction
    // Whole write frame; an unclaimed address is followed straight by stop
    task automatic smb_xfer(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d,
        output logic ok);
        logic a0;
        logic a1;
        logic a2;
        logic a3;
        u_sbe_smb_master.send_start();
        u_sbe_smb_master.send_byte(a, a0);
        ok = a0;
        if (a0) begin
            u_sbe_smb_master.send_byte(c, a1);
            u_sbe_smb_master.send_byte(d[7:0], a2);
            u_sbe_smb_master.send_byte(d[15:8], a3);
            ok = a1 & a2 & a3;
        end
        u_sbe_smb_master.send_stop();
        repeat (10) @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    logic [3:0] ctl_t [9] = '{4'h1, 4'h1, 4'h1, 4'h0, 4'h2, 4'h0, 4'h4, 4'h7, 4'h1};
    logic [7:0] adr_t [9] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h44, 8'h44, 8'h5A, 8'h22, 8'h11};
    initial begin : main
        logic [7:0] cmd;
        logic [15:0] d;
        logic [15:0] m;
        logic [1:0] e;
        logic ok;
        logic [7:0] cap_c;
        logic [15:0] cap_d;
        int ev0;
        int refused;
        int n_tx;
        {io_addr, io_wr, io_rd, io_wdata, eng_start, eng_rx_valid, eng_tx_req} = '0;
        eng_rx_data = 8'h00;
        sh1 = 8'h44;
        sh2 = 8'h5A;
        slave_cmd_match = 8'h00;
        cap_c = 8'h00;
        cap_d = 16'h0000;
        sys_rst = 1'b1;
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        // Reset values, reserved bits, read-only and unmapped places
        for (int a = 8; a < 15; a++) rd_chk(4'(a), 8'h00);
        io_wr_t(OFF_SLV_CTL, 8'hFF);
        rd_chk(OFF_SLV_CTL, 8'h0F);
        io_wr_t(OFF_CAP_CMD, 8'h5A);
        rd_chk(OFF_CAP_CMD, 8'h00);
        io_wr_t(OFF_MASK_HI, 8'hC3);
        rd_chk(OFF_MASK_HI, 8'hC3);
        // Fill all 32 places, rewind, read back one past the end to see the wrap
        rd_chk(OFF_HOST_CTL, 8'h00);
        for (int i = 0; i < 32; i++) begin
            blk[i] = 8'($random(seed));
            io_wr_t(OFF_BLK_DATA, blk[i]);
        end
        rd_chk(OFF_HOST_CTL, 8'h00);
        for (int i = 0; i < 33; i++) rd_chk(OFF_BLK_DATA, blk[i % 32]);
        // Engine bytes pile up in the FIFO while software writes stall the drain
        rd_chk(OFF_HOST_CTL, 8'h00);
        pulse_start();
        refused = 0;
        fork
            begin
                @(negedge clk_sys);
                io_addr = OFF_BLK_DATA;
                io_wdata = 8'hEE;
                io_wr = 1'b1;
                repeat (20) @(negedge clk_sys);
                io_wr = 1'b0;
            end
            begin
                for (int n = 0; n < 20; n++) begin
                    blk[n] = 8'($random(seed));
                    @(negedge clk_sys);
                    eng_rx_valid = 1'b1;
                    eng_rx_data = blk[n];
                    while (eng_rx_ready !== 1'b1) begin
                        @(negedge clk_sys);
                        refused++;
                    end
                end
                @(negedge clk_sys);
                eng_rx_valid = 1'b0;
            end
        join
        check(16'(refused != 0), 16'h1);
        repeat (30) @(negedge clk_sys);
        rd_chk(OFF_HOST_CTL, 8'h00);
        for (int i = 0; i < 32; i++) rd_chk(OFF_BLK_DATA, blk[i]);
        // Engine transmit of a legal block count, restarting at index zero
        n_tx = ($random(seed) & 31) + 1;
        pulse_start();
        for (int i = 0; i < n_tx; i++) begin
            @(negedge clk_sys);
            eng_tx_req = 1'b1;
            @(negedge clk_sys);
            eng_tx_req = 1'b0;
            check({7'h00, eng_tx_valid, eng_tx_data}, {8'h01, blk[i]});
        end
        // Slave port table: host hit, command miss, mask miss, disabled, shadows, refusals
        for (int i = 0; i < 9; i++) begin
            io_wr_t(OFF_SLV_CTL, {4'h0, ctl_t[i]});
            slave_cmd_match = 8'($random(seed));
            cmd = (i == 1) ? ~slave_cmd_match : slave_cmd_match;
            d = 16'($random(seed));
            if (d == 16'h0) d = 16'h0001;
            m = (i == 2) ? ~d : ((16'($random(seed)) & d) | (d & (~d + 16'h1)));
            io_wr_t(OFF_MASK_LO, m[7:0]);
            io_wr_t(OFF_MASK_HI, m[15:8]);
            rd_chk(OFF_MASK_LO, m[7:0]);
            e = exp_out(ctl_t[i], adr_t[i], cmd, d, m);
            ev0 = ev_cnt;
            smb_xfer(adr_t[i], cmd, d, ok);
            check({15'h0, ok}, {15'h0, e[1]});
            check(16'(ev_cnt - ev0), {15'h0, e[0]});
            if (e[1]) begin
                cap_c = cmd;
                cap_d = d;
            end
            rd_chk(OFF_CAP_CMD, cap_c);
            rd_chk(OFF_DATA_LO, cap_d[7:0]);
            rd_chk(OFF_DATA_HI, cap_d[15:8]);
        end
        // Alert line with the enable set, then cleared
        for (int k = 0; k < 2; k++) begin
            io_wr_t(OFF_SLV_CTL, (k == 0) ? 8'h08 : 8'h00);
            ev0 = ev_cnt;
            u_sbe_smb_master.alert_pulse();
            repeat (10) @(negedge clk_sys);
            check(16'(ev_cnt - ev0), (k == 0) ? 16'h1 : 16'h0);
        end
        final_report();
    end
endmodule
